// ==== bench/gpm_board.sv ====
`timescale 1ns/10ps
`default_nettype none
// board side of the pads: chip drive wins, then board drive, then pull-up
module gpm_board (
  input  wire logic        core_clk_i,
  input  wire logic [23:0] pin_o_i,
  input  wire logic [23:0] pin_oe_i,
  input  wire logic [23:0] pin_pu_en_i,
  input  wire logic [23:0] ext_en_i,
  input  wire logic [23:0] ext_val_i,
  output logic [23:0]      level_o
);
  logic [23:0] float_q = 24'h000000;
  // a floating pad wanders so a stale level can never pass for a real one
  always_ff @(posedge core_clk_i)
    float_q <= ~float_q;
  // per-pin wire resolution
  always_comb
    for (int i = 0; i < 24; i++)
      level_o[i] = pin_oe_i[i] ? pin_o_i[i] : ext_en_i[i] ? ext_val_i[i] :
                   pin_pu_en_i[i] ? 1'b1 : float_q[i];
endmodule
`default_nettype wire

// ==== bench/test_gpio_port_pin_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gpm_map.svh"
module test_gpio_port_pin_mux
  import gpm_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        soft_rst;
  logic        sleep;
  logic        pkg40;
  logic [1:0]  ckmode;
  logic        ccv;
  gpm_bus_t    bus;
  logic [31:0] rdata;
  logic [23:0] level;
  logic [23:0] pin_o;
  logic [23:0] pin_oe;
  logic [23:0] pu_en;
  logic [23:0] lai;
  logic        clk_in;
  logic        i2c_p0;
  logic        i2c_p1;
  logic [23:0] ext_en;
  logic [23:0] ext_val;
  gpm_alt_t    a1;
  gpm_alt_t    a2;
  gpm_alt_t    a3;
  int          num_errors = 0;
  int          check_count = 0;
  logic [3:0]  tbl [4] = '{4'hE, 4'hD, 4'h0, 4'hF};

  gpm_top u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .soft_rst_i(soft_rst), .sleep_i(sleep),
    .pkg_40lead_i(pkg40), .clocking_mode_field_i(ckmode), .core_clock_i(ccv),
    .bus_i(bus), .rdata_o(rdata), .pin_i(level), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .pin_pu_en_o(pu_en), .alt1_p0_i(a1), .alt2_p0_i(a2), .alt3_p0_i(a3),
    .alt1_p1_i(a1), .alt2_p1_i(a2), .alt3_p1_i(a3), .alt1_p2_i(a1), .alt2_p2_i(a2),
    .alt3_p2_i(a3), .logic_array_input_o(lai), .core_clock_pin_in_o(clk_in),
    .i2c1_on_p0_o(i2c_p0), .i2c1_on_p1_o(i2c_p1)
  );
  gpm_board u_board (
    .core_clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_pu_en_i(pu_en),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(level)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // let n edges pass, then look once their updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse_soft();
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    tick(2);
  endtask

  // boot pin sits high because p0.0 alternate one drives a one
  task automatic t_reset();
    rd_chk(`GPM_OFS_FSEL0, `GPM_RST_FSEL0);
    rd_chk(`GPM_OFS_FSEL1, `GPM_RST_FSEL1);
    rd_chk(`GPM_OFS_FSEL2, `GPM_RST_FSEL2);
    rd_chk(`GPM_OFS_PAD0, `GPM_RST_PAD0);
    rd_chk(`GPM_OFS_PAD1, `GPM_RST_PAD1);
    rd_chk(`GPM_OFS_DATA0, 32'h0000F1F1);
    rd_chk(32'hFFFFF410, 32'h00000000);
    chk({8'h00, lai}, {8'h00, level & 24'hFDFFFF});
    $display("reset test done");
  endtask
  // port 1 plus p0.6, the debug pins of port 0 stay untouched
  task automatic t_mux();
    wr(`GPM_OFS_DATA1, 32'hFF560000);
    tick(1);
    chk({pin_oe[15:8], pin_o[15:8]}, 32'h0000FF56);
    for (int c = 0; c < 4; c++)
    begin
      wr(`GPM_OFS_FSEL1, 32'h11 * c);
      tick(1);
      chk({pin_oe[9:8], pin_o[9:8] & pin_oe[9:8]}, tbl[c]);
    end
    wr(`GPM_OFS_FSEL1, 32'hFFFFFFFF);
    rd_chk(`GPM_OFS_FSEL1, 32'h33333333);
    wr(`GPM_OFS_FSEL1, 32'h11111111);
    wr(`GPM_OFS_DATA1, 32'h00560000);
    rd_chk(`GPM_OFS_DATA1, 32'h0056FFC1);
    chk({i2c_p0, i2c_p1}, 2'b00);
    @(posedge clk);
    pkg40 <= 1'b1;
    rd_chk(`GPM_OFS_DATA1, 32'h0056FF01);
    chk({i2c_p0, i2c_p1}, 2'b01);
    chk({8'h00, lai}, {8'h00, level & 24'hFDFFFF});
    @(posedge clk);
    pkg40 <= 1'b0;
    // p0.6 mode 2 only; the debug pin selectors keep their reset value
    wr(`GPM_OFS_FSEL0, 32'h02001111);
    tick(1);
    chk({i2c_p0, i2c_p1}, 2'b10);
    wr(`GPM_OFS_FSEL0, `GPM_RST_FSEL0);
    wr(`GPM_OFS_FSEL1, 32'h00000000);
    tick(1);
    chk(pin_oe[15:8], 32'h00);
    $display("mux test done");
  endtask
  // drive bits take the first write only; data is rewritten after each pad change
  task automatic t_pad();
    wr(`GPM_OFS_PAD1, 32'h00000003);
    wr(`GPM_OFS_DATA1, 32'h00560000);
    rd_chk(`GPM_OFS_PAD1, 32'h00000003);
    chk(pu_en[8], 1'b0);
    wr(`GPM_OFS_PAD1, 32'h00000004);
    wr(`GPM_OFS_DATA1, 32'h00560000);
    rd_chk(`GPM_OFS_PAD1, 32'h00000002);
    chk(pu_en[8], 1'b1);
    $display("pad test done");
  endtask
  task automatic t_sleep();
    wr(`GPM_OFS_DATA1, 32'hFF560000);
    // let the write reach the pads before they freeze
    @(posedge clk);
    sleep <= 1'b1;
    tick(2);
    wr(`GPM_OFS_DATA1, 32'hFFA90000);
    tick(2);
    chk({pin_oe[15:8], pin_o[15:8]}, 32'h0000FF56);
    @(posedge clk);
    sleep <= 1'b0;
    tick(2);
    chk({pin_oe[15:8], pin_o[15:8]}, 32'h0000FFA9);
    $display("sleep test done");
  endtask
  task automatic t_clk();
    wr(`GPM_OFS_FSEL1, 32'h00000200);
    ccv <= 1'b1;
    tick(2);
    chk({pin_oe[10], pin_o[10]}, 2'b11);
    @(posedge clk);
    ccv <= 1'b0;
    tick(2);
    chk({pin_oe[10], pin_o[10]}, 2'b10);
    @(posedge clk);
    ckmode <= 2'h3;
    ext_en[10] <= 1'b1;
    ext_val[10] <= 1'b1;
    tick(2);
    chk({pin_oe[10], clk_in}, 2'b01);
    @(posedge clk);
    ext_val[10] <= 1'b0;
    tick(2);
    chk({pin_oe[10], clk_in}, 2'b00);
    @(posedge clk);
    ckmode <= 2'h1;
    ext_en[10] <= 1'b0;
    $display("clock pin test done");
  endtask
  // retention bit decides whether a soft reset restores defaults
  task automatic t_soft();
    wr(`GPM_OFS_FSEL2, 32'h00000011);
    // p0.0 driven low at the recapture selects the boot-low default
    a1.dout[0] <= 1'b0;
    pulse_soft();
    rd_chk(`GPM_OFS_FSEL2, 32'h00000000);
    rd_chk(`GPM_OFS_FSEL0, 32'h00000001);
    chk(pin_oe[15:8], 32'h00);
    wr(`GPM_OFS_RCFG, 32'h00000001);
    a1.dout[0] <= 1'b1;
    wr(`GPM_OFS_FSEL2, 32'h00000011);
    pulse_soft();
    rd_chk(`GPM_OFS_FSEL2, 32'h00000011);
    $display("soft reset test done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang is cut short here
  initial
  begin
    #800000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'b0;
    soft_rst = 1'b0;
    sleep = 1'b0;
    pkg40 = 1'b0;
    ckmode = 2'h1;
    ccv = 1'b0;
    bus = '0;
    ext_en = 24'h000000;
    ext_val = 24'h000000;
    a1 = '{oe: 8'hFF, dout: 8'h01};
    a2 = '{oe: 8'h00, dout: 8'hFF};
    a3 = '{oe: 8'hFF, dout: 8'hFF};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_mux();
    t_pad();
    t_sleep();
    t_clk();
    t_soft();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== pkg/gpm_map.svh ====
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH
`define GPM_OFS_FSEL0 32'hFFFFF400
`define GPM_OFS_FSEL1 32'hFFFFF404
`define GPM_OFS_FSEL2 32'hFFFFF408
`define GPM_OFS_DATA0 32'hFFFFF420
`define GPM_OFS_PAD0  32'hFFFFF42C
`define GPM_OFS_DATA1 32'hFFFFF430
`define GPM_OFS_PAD1  32'hFFFFF43C
`define GPM_OFS_DATA2 32'hFFFFF440
`define GPM_OFS_PAD2  32'hFFFFF44C
`define GPM_OFS_RCFG  32'hFFFFF450
`define GPM_RST_FSEL0 32'h00001111
`define GPM_RST_FSEL1 32'h00000000
`define GPM_RST_FSEL2 32'h00000000
`define GPM_RST_PAD0  32'h22220000
`define GPM_RST_PAD1  32'h22000022
`define GPM_RST_PAD2  32'h00000000
`define GPM_DBG_MASK  32'h0000FFF0
`define GPM_POS_DIR   24
`define GPM_POS_OUT   16
`define GPM_POS_RLVL  8
`define GPM_NPORT     3
`define GPM_NPIN      8
`define GPM_CLKMODE_EXT 2'h3
`endif

// ==== pkg/gpm_pkg.sv ====
package gpm_pkg;
  typedef enum logic [1:0] {
    GPM_FN_GPIO = 2'b00,
    GPM_FN_ALT1 = 2'b01,
    GPM_FN_ALT2 = 2'b10,
    GPM_FN_ALT3 = 2'b11
  } gpm_fn_t;
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dout;
  } gpm_alt_t;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu_en;
  } gpm_pad_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gpm_bus_t;
endpackage

// ==== rtl/gpm_hold.sv ====
`timescale 1ns/10ps
`default_nettype none
// freezes pad drive while the device sleeps
module gpm_hold
  import gpm_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     sleep_i,
  input  wire gpm_pad_t live_i,
  output gpm_pad_t      pad_o
);
  gpm_pad_t held;
  gpm_pad_t next_held;
  // sample every cycle while awake so the frozen copy is current
  always_comb
  begin
    next_held = sleep_i ? held : live_i;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      held <= '0;
    else
      held <= next_held;
  end
  assign pad_o = sleep_i ? held : live_i;
  a_hold_frozen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sleep_i && $past(sleep_i) |-> pad_o == $past(pad_o))
    else $error("pads changed during power saving");
endmodule
`default_nettype wire

// ==== rtl/gpm_pad_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
// per-port pin mux: selector picks gpio or one of three alternates
module gpm_pad_mux
  import gpm_pkg::*;
(
  input  wire logic [31:0] fsel_i,
  input  wire logic [31:0] pad_i,
  input  wire logic [7:0]  dir_i,
  input  wire logic [7:0]  dout_i,
  input  wire logic [7:0]  pin_en_i,
  input  wire gpm_alt_t    alt1_i,
  input  wire gpm_alt_t    alt2_i,
  input  wire gpm_alt_t    alt3_i,
  output gpm_pad_t         pad_o
);
  // selector and pull-up bit for pin n both sit at 4n
  always_comb
  begin
    pad_o = '0;
    for (int n = 0; n < 8; n++)
    begin
      pad_o.pu_en[n] = pin_en_i[n] & ~pad_i[4*n];
      case (gpm_fn_t'(fsel_i[4*n +: 2]))
        GPM_FN_GPIO:
        begin
          pad_o.oe[n] = dir_i[n] & pin_en_i[n];
          pad_o.o[n]  = dout_i[n];
        end
        GPM_FN_ALT1:
        begin
          pad_o.oe[n] = alt1_i.oe[n] & pin_en_i[n];
          pad_o.o[n]  = alt1_i.dout[n];
        end
        GPM_FN_ALT2:
        begin
          pad_o.oe[n] = alt2_i.oe[n] & pin_en_i[n];
          pad_o.o[n]  = alt2_i.dout[n];
        end
        default:
        begin
          pad_o.oe[n] = alt3_i.oe[n] & pin_en_i[n];
          pad_o.o[n]  = alt3_i.dout[n];
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/gpm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gpm_map.svh"
// twenty-three-pin gpio with function mux, pad parameters and reset retention
module gpm_top
  import gpm_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        soft_rst_i,
  input  wire logic        sleep_i,
  input  wire logic        pkg_40lead_i,
  input  wire logic [1:0]  clocking_mode_field_i,
  input  wire logic        core_clock_i,
  input  wire gpm_bus_t    bus_i,
  output logic [31:0]      rdata_o,
  input  wire logic [23:0] pin_i,
  output logic [23:0]      pin_o,
  output logic [23:0]      pin_oe_o,
  output logic [23:0]      pin_pu_en_o,
  input  wire gpm_alt_t    alt1_p0_i,
  input  wire gpm_alt_t    alt2_p0_i,
  input  wire gpm_alt_t    alt3_p0_i,
  input  wire gpm_alt_t    alt1_p1_i,
  input  wire gpm_alt_t    alt2_p1_i,
  input  wire gpm_alt_t    alt3_p1_i,
  input  wire gpm_alt_t    alt1_p2_i,
  input  wire gpm_alt_t    alt2_p2_i,
  input  wire gpm_alt_t    alt3_p2_i,
  output logic [23:0]      logic_array_input_o,
  output logic             core_clock_pin_in_o,
  output logic             i2c1_on_p0_o,
  output logic             i2c1_on_p1_o
);
  // port 2 pin 1 is absent; bit 17 of the flat pin vector is never driven
  localparam logic [23:0] PIN_PRESENT = 24'hFDFFFF;
  typedef struct packed {
    logic [2:0][31:0] fsel;
    logic [2:0][31:0] pad;
    logic [2:0][7:0]  dir;
    logic [2:0][7:0]  dout;
    logic [2:0][7:0]  rlvl;
    logic [2:0]       drv_locked;
    logic             keep_cfg;
    logic             boot_level;
    logic             cap_pending;
    logic [31:0]      rdata;
  } gpm_state_t;
  gpm_state_t st;
  gpm_state_t next_st;
  gpm_pad_t   live [3];
  gpm_pad_t   frozen [3];
  gpm_alt_t   alt2_p0_r;
  gpm_alt_t   alt1_p1_r;
  gpm_alt_t   alt2_p1_r;
  logic [7:0] pin_in [3];
  // drive fields are bits 4n+2:4n+1, writable only before the first write
  function automatic logic [31:0] drv_mask();
    return 32'h66666666;
  endfunction
  // maps a byte address to port index, 3 when no match
  function automatic logic [1:0] port_of(input logic [31:0] a,
                                          input logic [31:0] b0,
                                          input logic [31:0] b1,
                                          input logic [31:0] b2);
    if (a == b0)
      return 2'd0;
    else if (a == b1)
      return 2'd1;
    else if (a == b2)
      return 2'd2;
    else
      return 2'd3;
  endfunction
  always_comb
  begin
    for (int p = 0; p < 3; p++)
      pin_in[p] = pin_i[8*p +: 8];
  end
  // register file, retention and capture
  always_comb
  begin
    logic [1:0]  fp;
    logic [1:0]  pp;
    logic [1:0]  dp;
    logic [31:0] keep;
    fp = port_of(bus_i.addr, `GPM_OFS_FSEL0, `GPM_OFS_FSEL1, `GPM_OFS_FSEL2);
    pp = port_of(bus_i.addr, `GPM_OFS_PAD0, `GPM_OFS_PAD1, `GPM_OFS_PAD2);
    dp = port_of(bus_i.addr, `GPM_OFS_DATA0, `GPM_OFS_DATA1, `GPM_OFS_DATA2);
    keep = '0;
    next_st = st;
    next_st.cap_pending = 1'b0;
    // first cycle after reset release: catch boot level and reset-time pins
    if (st.cap_pending)
    begin
      next_st.boot_level = pin_in[0][0];
      for (int p = 0; p < 3; p++)
        next_st.rlvl[p] = pin_in[p];
      if (!pin_in[0][0])
        next_st.fsel[0] = `GPM_RST_FSEL0 & ~`GPM_DBG_MASK;
    end
    if (bus_i.wr)
    begin
      if (fp != 2'd3)
        next_st.fsel[fp] = bus_i.wdata & 32'h33333333;
      else if (pp != 2'd3)
      begin
        keep = st.drv_locked[pp] ? drv_mask() : 32'h0;
        next_st.pad[pp] = ((bus_i.wdata & ~keep) | (st.pad[pp] & keep)) & 32'h77777777;
        next_st.drv_locked[pp] = 1'b1;
      end
      else if (dp != 2'd3)
      begin
        next_st.dir[dp]  = bus_i.wdata[`GPM_POS_DIR +: 8];
        next_st.dout[dp] = bus_i.wdata[`GPM_POS_OUT +: 8];
      end
      else if (bus_i.addr == `GPM_OFS_RCFG)
        next_st.keep_cfg = bus_i.wdata[0];
    end
    // software or watchdog reset restores defaults unless retention is set
    if (soft_rst_i && !st.keep_cfg)
    begin
      next_st.fsel = {`GPM_RST_FSEL2, `GPM_RST_FSEL1, `GPM_RST_FSEL0};
      next_st.pad  = {`GPM_RST_PAD2, `GPM_RST_PAD1, `GPM_RST_PAD0};
      next_st.dir  = '0;
      next_st.dout = '0;
      next_st.drv_locked  = '0;
      next_st.cap_pending = 1'b1;
    end
    // read data stand the cycle after the strobe; unmapped reads zero
    next_st.rdata = '0;
    if (bus_i.rd)
    begin
      if (fp != 2'd3)
        next_st.rdata = st.fsel[fp];
      else if (pp != 2'd3)
        next_st.rdata = st.pad[pp];
      else if (dp != 2'd3)
        next_st.rdata = {st.dir[dp], st.dout[dp], st.rlvl[dp], pin_in[dp]};
      else if (bus_i.addr == `GPM_OFS_RCFG)
        next_st.rdata = {31'h0, st.keep_cfg};
    end
  end
  // hardware reset always restores defaults; capture follows next cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.fsel <= {`GPM_RST_FSEL2, `GPM_RST_FSEL1, `GPM_RST_FSEL0};
      st.pad  <= {`GPM_RST_PAD2, `GPM_RST_PAD1, `GPM_RST_PAD0};
      st.cap_pending <= 1'b1;
    end
    else
      st <= next_st;
  end
  assign rdata_o = st.rdata;
  // p1.2 mode 2 drives core clock unless external clock mode is chosen
  always_comb
  begin
    alt1_p1_r = alt1_p1_i;
    alt2_p1_r = alt2_p1_i;
    alt2_p0_r = alt2_p0_i;
    alt2_p1_r.dout[2] = core_clock_i;
    alt2_p1_r.oe[2]   = (clocking_mode_field_i != `GPM_CLKMODE_EXT);
    // second i2c only where the package bonds it
    if (pkg_40lead_i)
    begin
      alt2_p0_r.oe[7:6] = 2'b00;
    end
    else
    begin
      alt1_p1_r.oe[7:6] = 2'b00;
    end
  end
  assign core_clock_pin_in_o = (clocking_mode_field_i == `GPM_CLKMODE_EXT) && pin_i[10];
  assign i2c1_on_p0_o = !pkg_40lead_i && (st.fsel[0][25:24] == 2'b10);
  assign i2c1_on_p1_o = pkg_40lead_i && (st.fsel[1][25:24] == 2'b01);
  gpm_pad_mux u_mux0 (
    .fsel_i   (st.fsel[0]),
    .pad_i    (st.pad[0]),
    .dir_i    (st.dir[0]),
    .dout_i   (st.dout[0]),
    .pin_en_i (PIN_PRESENT[7:0]),
    .alt1_i   (alt1_p0_i),
    .alt2_i   (alt2_p0_r),
    .alt3_i   (alt3_p0_i),
    .pad_o    (live[0])
  );
  gpm_pad_mux u_mux1 (
    .fsel_i   (st.fsel[1]),
    .pad_i    (st.pad[1]),
    .dir_i    (st.dir[1]),
    .dout_i   (st.dout[1]),
    .pin_en_i (PIN_PRESENT[15:8]),
    .alt1_i   (alt1_p1_r),
    .alt2_i   (alt2_p1_r),
    .alt3_i   (alt3_p1_i),
    .pad_o    (live[1])
  );
  gpm_pad_mux u_mux2 (
    .fsel_i   (st.fsel[2]),
    .pad_i    (st.pad[2]),
    .dir_i    (st.dir[2]),
    .dout_i   (st.dout[2]),
    .pin_en_i (PIN_PRESENT[23:16]),
    .alt1_i   (alt1_p2_i),
    .alt2_i   (alt2_p2_i),
    .alt3_i   (alt3_p2_i),
    .pad_o    (live[2])
  );
  for (genvar p = 0; p < 3; p++)
  begin : g_hold
    gpm_hold u_hold (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .sleep_i    (sleep_i),
      .live_i     (live[p]),
      .pad_o      (frozen[p])
    );
    assign pin_o[8*p +: 8]       = frozen[p].o;
    assign pin_oe_o[8*p +: 8]    = frozen[p].oe;
    assign pin_pu_en_o[8*p +: 8] = frozen[p].pu_en;
  end
  // the logic array sees every pin whatever its function
  assign logic_array_input_o = pin_i & PIN_PRESENT;
  a_rd_fsel0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_i.rd && bus_i.addr == `GPM_OFS_FSEL0 |=> rdata_o == $past(st.fsel[0]))
    else $error("function select readback wrong");
  a_rd_live_in: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_i.rd && bus_i.addr == `GPM_OFS_DATA1 |=> rdata_o[7:0] == $past(pin_i[15:8]))
    else $error("data input byte not live");
  a_drv_once: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.drv_locked[1] && !soft_rst_i |=> (st.pad[1] & 32'h66666666) ==
      $past(st.pad[1] & 32'h66666666))
    else $error("drive strength changed after first write");
  a_gpio_undriven: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sleep_i && st.fsel[2][1:0] == 2'b00 && !st.dir[2][0] |-> !pin_oe_o[16])
    else $error("gpio input pin driven");
  a_pullup_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sleep_i |-> pin_pu_en_o[12] == !st.pad[1][16])
    else $error("pull-up disagrees with pad params");
  a_keep_cfg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    soft_rst_i && st.keep_cfg && !bus_i.wr |=> st.fsel == $past(st.fsel))
    else $error("retention lost on soft reset");
  a_plain_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    soft_rst_i && !st.keep_cfg |=> st.fsel[1] == 32'h0 && st.dir == '0)
    else $error("soft reset left non-default config");
  a_core_clock_pin_dir: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sleep_i && st.fsel[1][9:8] == 2'b10 |-> pin_oe_o[10] ==
      (clocking_mode_field_i != 2'h3))
    else $error("core clock pin direction wrong");
  a_la_input: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    logic_array_input_o[7:0] == pin_i[7:0])
    else $error("logic array input gated");
endmodule
`default_nettype wire
